// [core/rss_start_sync.sv]
// Purpose: start trigger delay, start pin and shadow transfer control
// Assumes: serial clock half period of at least four ref_clk cycles
// Notes: registers reached only through the serial datagram port
`timescale 1ns/1ns
`default_nettype none
`include "rss_defines.svh"
module rss_start_sync (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic spi_sck,
  input wire logic spi_csn,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic start_pin_i,
  output logic start_pin_o,
  output logic start_pin_oe,
  input wire logic target_hit,
  input wire logic velocity_hit,
  input wire logic compare_point_hit,
  output logic int_start
);
  // ========================================================================
  // reset release
  logic rst_s1_reg, rst_n;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // ========================================================================
  // pin synchronisers: sck, csn, mosi, start
  logic [3:0] s1_reg, s2_reg, s3_reg, flt_reg, flt_prev_reg;
  logic [3:0] pins;
  assign pins = {start_pin_i, spi_mosi, spi_csn, spi_sck};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 4'h6;
      s2_reg <= 4'h6;
      s3_reg <= 4'h6;
      flt_reg <= 4'h6;
      flt_prev_reg <= 4'h6;
    end else if (clk_en) begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // a change counts only once stages two and three agree
      flt_reg <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & flt_reg);
      flt_prev_reg <= flt_reg;
    end
  end
  logic sck_rise, sck_fall, csn_fall, csn_rise, csn_low, mosi_bit;
  assign sck_rise = flt_reg[0] & ~flt_prev_reg[0];
  assign sck_fall = ~flt_reg[0] & flt_prev_reg[0];
  assign csn_fall = ~flt_reg[1] & flt_prev_reg[1];
  assign csn_rise = flt_reg[1] & ~flt_prev_reg[1];
  assign csn_low = ~flt_reg[1];
  assign mosi_bit = flt_reg[2];

  // ========================================================================
  // serial datagram: 8 address bits (msb = write) then 32 data bits
  logic [39:0] rx_reg;
  logic [5:0] bits_reg;
  logic [31:0] tx_reg;
  logic [1:0] ld_reg;
  logic commit;
  rss_pkg::rss_word_t rd_word;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_reg <= '0;
      bits_reg <= 6'h00;
    end else if (clk_en) begin
      if (csn_fall) begin
        bits_reg <= 6'h00;
      end else if (csn_low && sck_rise) begin
        rx_reg <= {rx_reg[38:0], mosi_bit};
        if (bits_reg != 6'h3f) begin
          bits_reg <= bits_reg + 6'h01;
        end
      end
    end
  end
  // read data of the memory arrive one cycle after the address settles
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_reg <= 2'h0;
    end else if (clk_en) begin
      ld_reg <= {ld_reg[0],
                 csn_low && sck_rise && bits_reg == `RSS_ADR_BITS - 6'h01};
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg <= '0;
      spi_miso <= 1'b0;
    end else if (clk_en) begin
      if (ld_reg[1]) begin
        tx_reg <= rd_word;
        spi_miso <= rd_word[31];
      end else if (csn_fall) begin
        tx_reg <= '0;
        spi_miso <= 1'b0;
      end else if (sck_fall && bits_reg > `RSS_ADR_BITS) begin
        tx_reg <= {tx_reg[30:0], 1'b0};
        spi_miso <= tx_reg[30];
      end
    end
  end
  // a write is taken over only when a full datagram closes
  assign commit = csn_rise && bits_reg == `RSS_DG_BITS && rx_reg[39];
  logic [6:0] wr_adr, rd_adr;
  logic [31:0] wr_dat;
  assign wr_adr = rx_reg[38:32];
  assign wr_dat = rx_reg[31:0];
  assign rd_adr = rx_reg[6:0];

  // ========================================================================
  // configuration registers
  rss_pkg::rss_word_t conf_reg, out_add_reg, delay_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conf_reg <= `RSS_CONF_RST;
      out_add_reg <= `RSS_OUT_ADD_RST;
      delay_reg <= `RSS_DELAY_RST;
    end else if (clk_en && commit) begin
      case (wr_adr)
        `RSS_ADR_CONF: conf_reg <= wr_dat;
        `RSS_ADR_OUT_ADD: out_add_reg <= wr_dat;
        `RSS_ADR_DELAY: delay_reg <= wr_dat;
        default: ;
      endcase
    end
  end
  logic [3:0] trig_sel;
  logic [4:0] start_en;
  logic pol, imm, cyc, pin_input;
  assign trig_sel = conf_reg[`RSS_TRIG_MSB:`RSS_TRIG_LSB];
  assign start_en = conf_reg[`RSS_EN_SHADOW:`RSS_EN_LSB];
  assign pol = conf_reg[`RSS_POL_BIT];
  assign imm = conf_reg[`RSS_IMM_BIT];
  assign cyc = conf_reg[`RSS_CYC_BIT];
  assign pin_input = trig_sel[0];

  // ========================================================================
  // trigger edges
  logic [2:0] ev_prev_reg;
  logic [2:0] ev_now, ev_edge;
  logic ext_trig, int_trig, cmp_trig, any_int;
  assign ev_now = {compare_point_hit, velocity_hit, target_hit};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_prev_reg <= 3'h0;
    end else if (clk_en) begin
      ev_prev_reg <= ev_now;
    end
  end
  assign ev_edge = ev_now & ~ev_prev_reg & trig_sel[3:1];
  assign int_trig = |ev_edge;
  assign cmp_trig = ev_edge[2];
  assign any_int = int_trig;
  // pin edge into the active level, never the level itself
  assign ext_trig = pin_input && (pol ? (flt_reg[3] & ~flt_prev_reg[3])
                                      : (~flt_reg[3] & flt_prev_reg[3]));

  // ========================================================================
  // delay countdown
  rss_pkg::rss_wait_t wait_reg;
  rss_pkg::rss_word_t cnt_reg;
  logic fire;
  always_comb begin
    fire = 1'b0;
    case (wait_reg)
      rss_pkg::RSS_IDLE: begin
        if (ext_trig && (imm || delay_reg == 32'h0)) begin
          fire = 1'b1;
        end else if (any_int && delay_reg == 32'h0) begin
          fire = 1'b1;
        end
      end
      rss_pkg::RSS_WAIT_INT, rss_pkg::RSS_WAIT_EXT: begin
        // an immediate external start cuts any countdown short
        fire = (cnt_reg == 32'h1) || (ext_trig && imm);
      end
      default: fire = 1'b0;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= rss_pkg::RSS_IDLE;
      cnt_reg <= '0;
    end else if (clk_en) begin
      case (wait_reg)
        rss_pkg::RSS_IDLE: begin
          if (!fire && ext_trig) begin
            wait_reg <= rss_pkg::RSS_WAIT_EXT;
            cnt_reg <= delay_reg;
          end else if (!fire && any_int) begin
            wait_reg <= rss_pkg::RSS_WAIT_INT;
            cnt_reg <= delay_reg;
          end
        end
        rss_pkg::RSS_WAIT_INT, rss_pkg::RSS_WAIT_EXT: begin
          // further triggers are dropped here unless immediate
          if (fire) begin
            wait_reg <= rss_pkg::RSS_IDLE;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg - 32'h1;
          end
        end
        default: wait_reg <= rss_pkg::RSS_IDLE;
      endcase
    end
  end

  // ========================================================================
  // internal start and start pin output
  logic act_reg;
  rss_pkg::rss_word_t left_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_start <= 1'b0;
      act_reg <= 1'b0;
      left_reg <= '0;
    end else if (clk_en) begin
      int_start <= fire;
      if (fire) begin
        act_reg <= 1'b1;
        left_reg <= out_add_reg;
      end else if (left_reg != 32'h0) begin
        left_reg <= left_reg - 32'h1;
      end else begin
        act_reg <= 1'b0;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_pin_o <= 1'b1;
      start_pin_oe <= 1'b0;
    end else if (clk_en) begin
      start_pin_o <= pol ? act_reg : ~act_reg;
      start_pin_oe <= trig_sel != 4'h0 && !pin_input;
    end
  end

  // ========================================================================
  // deferred target, velocity, mode and gearing writes
  rss_pkg::rss_word_t dval_reg [`RSS_DEFER_CNT];
  rss_pkg::rss_word_t dnew_reg [`RSS_DEFER_CNT];
  logic [3:0] dpend_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dpend_reg <= 4'h0;
      for (int i = 0; i < `RSS_DEFER_CNT; i++) begin
        dval_reg[i] <= '0;
        dnew_reg[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < `RSS_DEFER_CNT; i++) begin
        if (fire && dpend_reg[i]) begin
          dval_reg[i] <= dnew_reg[i];
          dpend_reg[i] <= 1'b0;
        end
        // a write in the start cycle is kept, not lost
        if (commit && wr_adr == `RSS_ADR_DEFER + 7'(i)) begin
          if (start_en[i]) begin
            dnew_reg[i] <= wr_dat;
            dpend_reg[i] <= 1'b1;
          end else begin
            dval_reg[i] <= wr_dat;
          end
        end
      end
    end
  end

  // ========================================================================
  // shadow transfer and register read back
  logic in_shd_w, in_act_w, in_shd_r, in_act_r, shd_load;
  rss_pkg::rss_word_t mem_rd;
  assign in_shd_w = wr_adr >= `RSS_ADR_SHADOW && wr_adr < `RSS_ADR_ACTIVE;
  assign in_act_w = wr_adr >= `RSS_ADR_ACTIVE && wr_adr < `RSS_ADR_DEFER;
  assign in_shd_r = rd_adr >= `RSS_ADR_SHADOW && rd_adr < `RSS_ADR_ACTIVE;
  assign in_act_r = rd_adr >= `RSS_ADR_ACTIVE && rd_adr < `RSS_ADR_DEFER;
  assign shd_load = fire && start_en[4] && trig_sel != 4'h0;
  rss_ramp_mem #(.N(`RSS_SHADOW_CNT), .W(32)) u_mem (
    .clk(ref_clk),
    .rst_n(rst_n),
    .ce(clk_en),
    .wr_en(commit && (in_shd_w || in_act_w)),
    .wr_bank(in_act_w),
    .wr_idx(wr_adr[3:0]),
    .wr_data(wr_dat),
    .rd_bank(in_act_r),
    .rd_idx(rd_adr[3:0]),
    .rd_data(mem_rd),
    .load(shd_load),
    .cyclic(cyc)
  );
  always_comb begin
    rd_word = '0;
    if (in_shd_r || in_act_r) begin
      rd_word = mem_rd;
    end else if (rd_adr >= `RSS_ADR_DEFER &&
                 rd_adr < `RSS_ADR_DEFER + 7'h04) begin
      rd_word = dval_reg[rd_adr[1:0]];
    end else begin
      case (rd_adr)
        `RSS_ADR_CONF: rd_word = conf_reg;
        `RSS_ADR_OUT_ADD: rd_word = out_add_reg;
        `RSS_ADR_DELAY: rd_word = delay_reg;
        default: rd_word = '0;
      endcase
    end
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !clk_en);

  a_zero_delay: assert property ((wait_reg == rss_pkg::RSS_IDLE
      && any_int && delay_reg == 32'h0) |=> int_start)
    else $error("zero delay start missing");
  a_delay_three: assert property ((wait_reg == rss_pkg::RSS_IDLE
      && any_int && !ext_trig && delay_reg == 32'h3) |=>
      (!int_start [*3] ##1 int_start) or (1'b1 ##1 (ext_trig && imm)))
    else $error("delay of three cycles not kept");
  a_ext_delayed: assert property ((wait_reg == rss_pkg::RSS_IDLE
      && ext_trig && !imm && delay_reg != 32'h0) |=>
      wait_reg == rss_pkg::RSS_WAIT_EXT && !int_start)
    else $error("external trigger not delayed");
  a_imm_ext: assert property ((ext_trig && imm) |=>
      int_start && wait_reg == rss_pkg::RSS_IDLE)
    else $error("immediate external start missing");
  a_busy_ignore: assert property ((wait_reg != rss_pkg::RSS_IDLE
      && cnt_reg > 32'h1 && !(ext_trig && imm)) |=> !int_start
      && cnt_reg == $past(cnt_reg) - 32'h1)
    else $error("trigger accepted during countdown");
  a_pulse_start: assert property (fire |=> act_reg
      && left_reg == $past(out_add_reg) ##1 start_pin_o == pol)
    else $error("pulse not started");
  a_pulse_one: assert property ((fire && out_add_reg == 32'h0)
      ##1 !fire |=> !act_reg)
    else $error("single cycle pulse too long");
  a_pin_level: assert property (##1 start_pin_o ==
      ($past(pol) ~^ $past(act_reg)))
    else $error("start pin polarity wrong");
  a_write_end: assert property ((commit && wr_adr == `RSS_ADR_DELAY)
      |=> delay_reg == $past(wr_dat) && csn_low == 1'b0)
    else $error("write not taken at datagram end");
  a_shadow_go: assert property (shd_load |=> int_start
      && u_mem.act_reg[0] == $past(u_mem.shd_reg[0]))
    else $error("shadow load not tied to start");

  c_delayed: cover property (wait_reg == rss_pkg::RSS_WAIT_INT ##[1:20]
      int_start);
  c_imm_cut: cover property (wait_reg != rss_pkg::RSS_IDLE && ext_trig && imm);
  c_swap: cover property (shd_load && cyc);
  c_long_pulse: cover property (fire && out_add_reg > 32'h2);
endmodule
`default_nettype wire

// [core/rss_defines.svh]
// Purpose: constants of the ramp-start synchronisation unit
// Assumes: included by bare name, definitions only
// Notes: offsets are serial-port register addresses
//
// What this block does
// - internal start follows a recognised trigger after exactly delay plus one cycles
// - delay of zero gives the internal start right after the trigger
// - external pin triggers get the same delay by default
// - immediate-external bit: external trigger starts at once, cancels countdown
// - polarity clear: pin low active, falling edge triggers, output pulses low
// - polarity set: pin high active, rising edge triggers, output pulses high
// - output pin active one cycle per start with extension zero
// - output pin stays active extension plus one cycles per start
// - serial writes take effect only at the end of a datagram
// - external trigger ignored during compare-started countdown unless immediate
// - compare event ignored while an externally started process pends
// - fourteen shadow ramp registers copied to active set on start
// - shadow enable plus any trigger source: every start loads shadows
// - cyclic bit: start swaps shadow and active ramp sets
// - trigger is the edge into active state; start is a later pulse
// - trigger field: zero off, bit0 pin input, bits1-3 internal events
// - start-enable bits defer target, velocity, mode, gearing, shadow writes
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// ==========================================================================
// register addresses
`define RSS_ADR_CONF 7'h02
`define RSS_ADR_OUT_ADD 7'h11
`define RSS_ADR_DELAY 7'h13
`define RSS_ADR_SHADOW 7'h40
`define RSS_ADR_ACTIVE 7'h50
`define RSS_ADR_DEFER 7'h60

// ==========================================================================
// configuration fields
`define RSS_EN_LSB 0
`define RSS_EN_SHADOW 4
`define RSS_TRIG_LSB 5
`define RSS_TRIG_MSB 8
`define RSS_POL_BIT 9
`define RSS_IMM_BIT 10
`define RSS_CYC_BIT 11

// ==========================================================================
// reset values and datagram framing
`define RSS_CONF_RST 32'h0000_0000
`define RSS_OUT_ADD_RST 32'h0000_0000
`define RSS_DELAY_RST 32'h0000_0000
`define RSS_DG_BITS 6'h28
`define RSS_ADR_BITS 6'h08
`define RSS_SHADOW_CNT 14
`define RSS_DEFER_CNT 4

`endif

// [core/rss_pkg.sv]
// Purpose: types of the ramp-start synchronisation unit
// Assumes: nothing
// Notes: used as rss_pkg::name, never imported
package rss_pkg;
  typedef logic [31:0] rss_word_t;
  typedef enum logic [1:0] {RSS_IDLE, RSS_WAIT_INT, RSS_WAIT_EXT} rss_wait_t;
endpackage

// [core/rss_ramp_mem.sv]
// Purpose: shadow and active ramp parameter sets
// Assumes: one write port from the serial side, registered read
// Notes: a start load has priority over a serial write
`timescale 1ns/1ns
`default_nettype none
module rss_ramp_mem #(
  parameter int N = 14,
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic wr_bank,
  input wire logic [3:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_bank,
  input wire logic [3:0] rd_idx,
  output logic [W-1:0] rd_data,
  input wire logic load,
  input wire logic cyclic
);
  logic [W-1:0] shd_reg [N];
  logic [W-1:0] act_reg [N];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        shd_reg[i] <= '0;
        act_reg[i] <= '0;
      end
    end else if (ce) begin
      if (load) begin
        for (int i = 0; i < N; i++) begin
          act_reg[i] <= shd_reg[i];
          if (cyclic) begin
            shd_reg[i] <= act_reg[i];
          end
        end
      end else if (wr_en && 32'(wr_idx) < N) begin
        if (wr_bank) begin
          act_reg[wr_idx] <= wr_data;
        end else begin
          shd_reg[wr_idx] <= wr_data;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (ce) begin
      if (32'(rd_idx) >= N) begin
        rd_data <= '0;
      end else begin
        rd_data <= rd_bank ? act_reg[rd_idx] : shd_reg[rd_idx];
      end
    end
  end
endmodule
`default_nettype wire

// [tb/rss_start_peer.sv]
// Purpose: far end of the start pin, a second synchronised controller
// Assumes: sees the resolved pin level and the unit's drive enable
// Notes: drives its own level only while the unit leaves the pin as input
`timescale 1ns/1ns
`default_nettype none
module rss_start_peer (
  input wire logic clk,
  input wire logic pol,
  input wire logic act,
  input wire logic pin,
  input wire logic dut_oe,
  output logic drv,
  output logic [7:0] width
);
  // no reset here: any idle cycle clears the count
  logic [7:0] run_cnt;
  // ==========================================================================
  // trigger source: an edge into the active level starts the unit
  assign drv = act ? pol : ~pol;
  // ==========================================================================
  // width of each active pulse the unit sends out
  always_ff @(posedge clk) begin
    if (dut_oe && pin == pol) begin
      run_cnt <= run_cnt + 8'h01;
    end else begin
      if (run_cnt != 8'h00) width <= run_cnt;
      run_cnt <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// [tb/rss_start_sync_tb.sv]
// Purpose: self-checking bench of the ramp-start unit
// Assumes: serial half period of 8 ref_clk cycles
// Notes: latencies mostly compared against each other, not absolute
`timescale 1ns/1ns
`default_nettype none
module rss_start_sync_tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic sck = 1'b0;
  logic csn = 1'b1;
  logic mosi = 1'b0;
  logic pol = 1'b0;
  logic act = 1'b0;
  logic tgt = 1'b0;
  logic vel = 1'b0;
  logic cmp = 1'b0;
  logic en = 1'b1;
  logic miso, pin_o, pin_oe, ist, drv;
  logic [7:0] width;
  wire logic pin;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  assign pin = pin_oe ? pin_o : drv;
  rss_start_sync dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(en),
    .spi_sck(sck), .spi_csn(csn), .spi_mosi(mosi), .spi_miso(miso),
    .start_pin_i(pin), .start_pin_o(pin_o), .start_pin_oe(pin_oe),
    .target_hit(tgt), .velocity_hit(vel), .compare_point_hit(cmp),
    .int_start(ist));
  rss_start_peer peer (.clk(ref_clk), .pol(pol), .act(act), .pin(pin),
    .dut_oe(pin_oe), .drv(drv), .width(width));
  initial forever #4 ref_clk = ~ref_clk;
  // ==========================================================================
  // common tasks
  task automatic conclude;
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // hang guard: whole run needs roughly 60k cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      conclude;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
      input string m);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // n below 40 makes a truncated datagram
  task automatic spi(input logic w, input logic [6:0] a,
      input logic [31:0] d, input int n, output logic [31:0] q);
    logic [39:0] f;
    f = {w, a, d};
    q = 32'h0000_0000;
    csn = 1'b0;
    tick(8);
    for (int i = 39; i > 39 - n; i--) begin
      mosi = f[i];
      tick(8);
      sck = 1'b1;
      if (i < 32) q[i] = miso;
      tick(8);
      sck = 1'b0;
    end
    tick(8);
    csn = 1'b1;
    tick(16);
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] q;
    spi(1'b1, a, d, 40, q);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [31:0] e,
      input string m);
    logic [31:0] q;
    spi(1'b0, a, 32'h0000_0000, 40, q);
    chk(q, e, m);
  endtask
  // unit disabled while the peer's idle level follows the new polarity
  task automatic cfg(input logic [3:0] tr, input logic [4:0] en,
      input logic p, input logic imm, input logic cy,
      input logic [31:0] dl, input logic [31:0] oa);
    wr(7'h02, 32'h0000_0000);
    pol = p;
    wr(7'h13, dl);
    wr(7'h11, oa);
    wr(7'h02, {20'h00000, cy, imm, p, tr, en});
  endtask
  task automatic drive(input logic [3:0] m);
    {cmp, vel, tgt, act} = {cmp, vel, tgt, act} | m;
  endtask
  // sources m0 fire at cycle 0, m2 at cycle t2; first start and count
  task automatic run(input logic [3:0] m0, input int t2,
      input logic [3:0] m2, output int lat, output int n);
    lat = -1;
    n = 0;
    for (int c = 0; c < 60; c++) begin
      if (c == 0) drive(m0);
      if (c == t2) drive(m2);
      tick(1);
      if (ist === 1'b1) begin
        if (n == 0) lat = c;
        n++;
      end
    end
    {cmp, vel, tgt, act} = 4'h0;
    tick(4);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs;
    logic [31:0] q;
    rdc(7'h02, 32'h0000_0000, "conf reset");
    rdc(7'h11, 32'h0000_0000, "extension reset");
    rdc(7'h13, 32'h0000_0000, "delay reset");
    wr(7'h13, 32'h1234_5678);
    rdc(7'h13, 32'h1234_5678, "delay readback");
    spi(1'b1, 7'h13, 32'h0000_00aa, 39, q);
    rdc(7'h13, 32'h1234_5678, "short datagram taken");
    rdc(7'h7f, 32'h0000_0000, "unmapped read");
    $display("test regs done");
  endtask
  task automatic t_delay;
    int l0, l, n;
    for (int p = 0; p < 2; p++) begin
      cfg(4'h2, 5'h00, p[0], 1'b0, 1'b0, 32'h0, 32'(2 * p));
      run(4'h2, -1, 4'h0, l0, n);
      chk(32'(n), 1, "one start per trigger");
      chk(32'(l0), 0, "undelayed start late");
      chk({24'h0, width}, 32'(2 * p + 1), "pin pulse width");
      chk({30'h0, pin_oe, pin_o}, {30'h0, 1'b1, ~p[0]}, "pin idle");
    end
    for (int s = 1; s < 4; s++) begin
      cfg(4'(1 << s), 5'h00, 1'b1, 1'b0, 1'b0, 32'h3, 32'h0);
      run(4'(1 << s), -1, 4'h0, l, n);
      chk(32'(l), 32'(l0 + 3), "delayed start");
      chk(32'(n), 1, "delayed start count");
    end
    cfg(4'h0, 5'h00, 1'b1, 1'b0, 1'b0, 32'h0, 32'h0);
    run(4'he, -1, 4'h0, l, n);
    chk(32'(n), 0, "start with no source");
    $display("test delay done");
  endtask
  // clock enable low must hold a running countdown
  task automatic t_freeze;
    cfg(4'h2, 5'h00, 1'b1, 1'b0, 1'b0, 32'h3, 32'h0);
    tgt = 1'b1;
    tick(2);
    en = 1'b0;
    tick(10);
    chk({31'h0, ist}, 32'h0, "start while frozen");
    en = 1'b1;
    tick(1);
    chk({31'h0, ist}, 32'h0, "start early after freeze");
    tick(1);
    chk({31'h0, ist}, 32'h1, "start lost after freeze");
    tgt = 1'b0;
    tick(4);
    $display("test freeze done");
  endtask
  task automatic t_ext;
    int l0, l, n;
    for (int p = 0; p < 2; p++) begin
      cfg(4'h1, 5'h00, p[0], 1'b0, 1'b0, 32'h0, 32'h0);
      run(4'h1, -1, 4'h0, l0, n);
      chk({31'h0, pin_oe}, 32'h0, "pin not input");
      cfg(4'h1, 5'h00, p[0], 1'b0, 1'b0, 32'h3, 32'h0);
      run(4'h1, -1, 4'h0, l, n);
      chk(32'(l), 32'(l0 + 3), "external delay");
    end
    $display("test external done");
  endtask
  task automatic t_prio;
    int lc, lp, li, l, n;
    cfg(4'h9, 5'h00, 1'b1, 1'b0, 1'b0, 32'd20, 32'h0);
    run(4'h8, -1, 4'h0, lc, n);
    run(4'h8, 5, 4'h1, l, n);
    chk(32'(l), 32'(lc), "pin during compare delay");
    chk(32'(n), 1, "pin during compare count");
    run(4'h1, -1, 4'h0, lp, n);
    run(4'h1, 8, 4'h8, l, n);
    chk(32'(l), 32'(lp), "compare during pin delay");
    chk(32'(n), 1, "compare during pin count");
    cfg(4'h9, 5'h00, 1'b1, 1'b1, 1'b0, 32'd20, 32'h0);
    run(4'h1, -1, 4'h0, li, n);
    chk(32'(li), 32'(lp - 20), "immediate pin start");
    run(4'h8, 5, 4'h1, l, n);
    chk(32'(l), 32'(li + 5), "pin cuts countdown");
    chk(32'(n), 1, "cut countdown count");
    $display("test priority done");
  endtask
  task automatic t_shadow;
    int l, n;
    cfg(4'h2, 5'h00, 1'b1, 1'b0, 1'b0, 32'h0, 32'h0);
    wr(7'h61, 32'h0000_1111);
    cfg(4'h2, 5'h12, 1'b1, 1'b0, 1'b0, 32'h0, 32'h0);
    wr(7'h61, 32'h0000_2222);
    wr(7'h40, 32'haaaa_0000);
    wr(7'h4d, 32'hbbbb_0000);
    rdc(7'h61, 32'h0000_1111, "deferred write early");
    run(4'h2, -1, 4'h0, l, n);
    rdc(7'h61, 32'h0000_2222, "deferred write lost");
    rdc(7'h50, 32'haaaa_0000, "first shadow load");
    rdc(7'h5d, 32'hbbbb_0000, "last shadow load");
    cfg(4'h2, 5'h10, 1'b1, 1'b0, 1'b1, 32'h0, 32'h0);
    wr(7'h40, 32'hcccc_0000);
    run(4'h2, -1, 4'h0, l, n);
    rdc(7'h50, 32'hcccc_0000, "cyclic load");
    rdc(7'h40, 32'haaaa_0000, "cyclic write back");
    $display("test shadow done");
  endtask
  initial begin
    tick(16);
    rstn = 1'b1;
    tick(8);
    t_regs;
    t_delay;
    t_freeze;
    t_ext;
    t_prio;
    t_shadow;
    conclude;
  end
endmodule
`default_nettype wire
